/* File: logic/rtc_watchdog_interrupt_logic.sv */
// Watchdog, event flags, interrupt output and square-wave select of the RTC.
// Assumes Avalon-MM master on i_clk; oscillator and status pins are asynchronous.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps

module rtc_watchdog_interrupt_logic #(
	parameter int PULSE_TICKS = rtc_wd_irq_pkg::PULSE_TICKS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Nonvolatile recall, same clock
	input wire logic i_nv_recall,
	input wire logic [7:0] i_nv_int_ctrl,
	input wire logic [7:0] i_nv_wd_ctrl,
	// Asynchronous pins and monitors
	input wire logic i_osc_clk,
	input wire logic i_osc_running,
	input wire logic i_on_backup,
	input wire logic i_alarm_match,
	input wire logic i_powerfail,
	input wire logic i_backup_low,
	input wire logic i_osc_fail,
	// Interrupt pin
	output logic o_int_out,
	output logic o_int_oe
);
	// Wave picked from the oscillator divider
	function automatic logic wave_bit(input logic [1:0] sel, input logic [14:0] div,
		input logic osc);
		case (sel)
			rtc_wd_irq_pkg::FREQ_1HZ: wave_bit = div[14];
			rtc_wd_irq_pkg::FREQ_512HZ: wave_bit = div[5];
			rtc_wd_irq_pkg::FREQ_4096HZ: wave_bit = div[2];
			default: wave_bit = osc;
		endcase
	endfunction

	logic [rtc_wd_irq_pkg::PIN_N-1:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
	logic [14:0] div_ff, nxt_div;
	logic tick_osc, tick32, osc_ok, on_backup;
	logic [7:0] flags_ff, nxt_flags;
	logic [7:0] intc_ff, nxt_intc;
	logic [6:0] wdc_ff, nxt_wdc;
	logic [7:0] rep_ff, nxt_rep;
	logic bklow_ff, nxt_bklow;
	logic wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [3:0] idx;
	logic req, ack, wr_wd, strobe, wd_load, flags_read;
	logic [5:0] new_timeout;
	logic [5:0] wd_cnt_ff, nxt_wd_cnt;
	logic wd_expire;
	logic [2:0] pulse_ff, nxt_pulse;
	logic irq_prev_ff, irq_cond, irq_act, any_en, drive, assert_lvl;
	logic int_out_ff, int_oe_ff, nxt_int_out, nxt_int_oe;

	// Two-stage synchronisers; edge detectors compare the second stage with its one-cycle-delayed copy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			pin_prev_ff <= '0;
		end else begin
			pin_meta_ff <= {i_osc_fail, i_backup_low, i_powerfail, i_alarm_match,
				i_on_backup, i_osc_running, i_osc_clk};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	// Oscillator divider; one enable pulse per rising crystal edge while the oscillator runs
	always_comb begin
		osc_ok = pin_sync_ff[rtc_wd_irq_pkg::P_RUN];
		on_backup = pin_sync_ff[rtc_wd_irq_pkg::P_BACKUP];
		tick_osc = pin_sync_ff[rtc_wd_irq_pkg::P_OSC] & ~pin_prev_ff[rtc_wd_irq_pkg::P_OSC]
			& osc_ok;
		tick32 = tick_osc && (div_ff[9:0] == rtc_wd_irq_pkg::TICK_DIV_LAST);
		nxt_div = tick_osc ? div_ff + 15'h0001 : div_ff;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_ff <= 15'h0000;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// Bus decode and strobes shared by the register and watchdog groups
	always_comb begin
		idx = i_avs_address[5:2];
		req = i_avs_read | i_avs_write;
		// Access lands on the edge where waitrequest is seen low
		ack = req & ~wait_ff;
		flags_read = ack & i_avs_read & (idx == rtc_wd_irq_pkg::REG_FLAGS);
		wr_wd = ack & i_avs_write & (idx == rtc_wd_irq_pkg::REG_WD_CTRL);
		strobe = wr_wd & i_avs_writedata[rtc_wd_irq_pkg::W_STROBE];
		wd_load = strobe | i_nv_recall;
		if (i_nv_recall) begin
			new_timeout = i_nv_wd_ctrl[5:0];
		end else if (wr_wd && !i_avs_writedata[rtc_wd_irq_pkg::W_LOCK]) begin
			new_timeout = i_avs_writedata[5:0];
		end else begin
			new_timeout = wdc_ff[5:0];
		end
	end

	// Watchdog down counter
	always_comb begin
		nxt_wd_cnt = wd_cnt_ff;
		wd_expire = 1'b0;
		if (wd_load) begin
			nxt_wd_cnt = new_timeout;
		end else if (tick32 && wdc_ff[5:0] != 6'h00) begin
			if (wd_cnt_ff == 6'h01) begin
				wd_expire = 1'b1;
				nxt_wd_cnt = wdc_ff[5:0];
			end else if (wd_cnt_ff == 6'h00) begin
				nxt_wd_cnt = wdc_ff[5:0];
			end else begin
				nxt_wd_cnt = wd_cnt_ff - 6'h01;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_cnt_ff <= 6'h00;
		end else begin
			wd_cnt_ff <= nxt_wd_cnt;
		end
	end

	// Registers, flags and bus answer
	always_comb begin
		nxt_flags = flags_ff;
		nxt_intc = intc_ff;
		nxt_wdc = {wdc_ff[6], new_timeout};
		nxt_rep = rep_ff;
		nxt_bklow = bklow_ff | pin_sync_ff[rtc_wd_irq_pkg::P_BKLOW];
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		if (req && wait_ff) begin
			// One wait cycle; data and reported flags captured here
			nxt_wait = 1'b0;
			nxt_rep = 8'h00;
			case (idx)
				rtc_wd_irq_pkg::REG_FLAGS: begin
					nxt_rdata = {24'h000000, flags_ff};
					nxt_rep = flags_ff & rtc_wd_irq_pkg::READ_CLEAR_MASK;
				end
				rtc_wd_irq_pkg::REG_INT_CTRL: nxt_rdata = {24'h000000, intc_ff};
				rtc_wd_irq_pkg::REG_WD_CTRL: nxt_rdata = {25'h0000000, wdc_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
		if (ack && i_avs_write) begin
			case (idx)
				rtc_wd_irq_pkg::REG_FLAGS: begin
					// flag bits other than unlock take a bus write only while unlocked
					if (flags_ff[rtc_wd_irq_pkg::F_UNLOCK]) begin
						nxt_flags = i_avs_writedata[7:0];
					end else begin
						nxt_flags[rtc_wd_irq_pkg::F_UNLOCK] =
							i_avs_writedata[rtc_wd_irq_pkg::F_UNLOCK];
					end
				end
				rtc_wd_irq_pkg::REG_INT_CTRL: nxt_intc = i_avs_writedata[7:0];
				rtc_wd_irq_pkg::REG_WD_CTRL: nxt_wdc[6] = i_avs_writedata[rtc_wd_irq_pkg::W_LOCK];
				default: nxt_wdc[6] = wdc_ff[6];
			endcase
		end
		// clear only what the read reported
		if (flags_read) begin
			nxt_flags = nxt_flags & ~rep_ff;
		end
		if (i_nv_recall) begin
			// stored wave and interrupt setup restored
			nxt_intc = i_nv_int_ctrl;
			nxt_wdc[6] = i_nv_wd_ctrl[rtc_wd_irq_pkg::W_LOCK];
			nxt_flags = flags_ff & (8'h01 << rtc_wd_irq_pkg::F_OSC_FAILED);
		end
		// sets come last so they win
		if (wd_expire) begin
			nxt_flags[rtc_wd_irq_pkg::F_WD_EXPIRED] = 1'b1;
		end
		if (pin_sync_ff[rtc_wd_irq_pkg::P_ALARM] && !pin_prev_ff[rtc_wd_irq_pkg::P_ALARM]) begin
			nxt_flags[rtc_wd_irq_pkg::F_ALARM] = 1'b1;
		end
		if (pin_sync_ff[rtc_wd_irq_pkg::P_PF] && !pin_prev_ff[rtc_wd_irq_pkg::P_PF]) begin
			nxt_flags[rtc_wd_irq_pkg::F_POWERFAIL] = 1'b1;
		end
		if (pin_sync_ff[rtc_wd_irq_pkg::P_OSCFAIL] && !pin_prev_ff[rtc_wd_irq_pkg::P_OSCFAIL]) begin
			nxt_flags[rtc_wd_irq_pkg::F_OSC_FAILED] = 1'b1;
		end
		// low backup seen at any time since the last return from backup, flagged on the next return
		if (!on_backup && pin_prev_ff[rtc_wd_irq_pkg::P_BACKUP]) begin
			if (nxt_bklow) begin
				nxt_flags[rtc_wd_irq_pkg::F_BACKUP_FAIL] = 1'b1;
			end
			nxt_bklow = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_ff <= rtc_wd_irq_pkg::FLAGS_RST;
			intc_ff <= rtc_wd_irq_pkg::INT_CTRL_RST;
			wdc_ff <= rtc_wd_irq_pkg::WD_CTRL_RST;
			rep_ff <= 8'h00;
			bklow_ff <= 1'b0;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else begin
			flags_ff <= nxt_flags;
			intc_ff <= nxt_intc;
			wdc_ff <= nxt_wdc;
			rep_ff <= nxt_rep;
			bklow_ff <= nxt_bklow;
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// Interrupt condition, pulse timer and pin driver
	always_comb begin
		any_en = intc_ff[rtc_wd_irq_pkg::C_WD_IRQ_EN] | intc_ff[rtc_wd_irq_pkg::C_ALARM_IRQ_EN]
			| intc_ff[rtc_wd_irq_pkg::C_PF_IRQ_EN];
		irq_cond = ((flags_ff[rtc_wd_irq_pkg::F_WD_EXPIRED] & intc_ff[rtc_wd_irq_pkg::C_WD_IRQ_EN])
			| (flags_ff[rtc_wd_irq_pkg::F_ALARM] & intc_ff[rtc_wd_irq_pkg::C_ALARM_IRQ_EN])
			| (flags_ff[rtc_wd_irq_pkg::F_POWERFAIL] & intc_ff[rtc_wd_irq_pkg::C_PF_IRQ_EN]))
			& ~on_backup;
		nxt_pulse = pulse_ff;
		if (flags_read) begin
			nxt_pulse = 3'h0;
		end else if (irq_cond && !irq_prev_ff) begin
			// pulse length in 32 Hz ticks
			nxt_pulse = 3'(PULSE_TICKS);
		end else if (tick32 && pulse_ff != 3'h0) begin
			nxt_pulse = pulse_ff - 3'h1;
		end
		if (intc_ff[rtc_wd_irq_pkg::C_PULSE_MODE]) begin
			irq_act = (pulse_ff != 3'h0) & ~on_backup;
		end else begin
			irq_act = irq_cond;
		end
		// fixed source priority on the pin
		drive = 1'b0;
		assert_lvl = 1'b0;
		if (on_backup) begin
			drive = 1'b0;
		end else if (flags_ff[rtc_wd_irq_pkg::F_CAL]) begin
			drive = 1'b1;
			assert_lvl = wave_bit(rtc_wd_irq_pkg::FREQ_512HZ, div_ff,
				pin_sync_ff[rtc_wd_irq_pkg::P_OSC]);
		end else if (intc_ff[rtc_wd_irq_pkg::C_SQW_EN]) begin
			drive = 1'b1;
			assert_lvl = wave_bit(intc_ff[rtc_wd_irq_pkg::C_FREQ_HI:rtc_wd_irq_pkg::C_FREQ_LO],
				div_ff, pin_sync_ff[rtc_wd_irq_pkg::P_OSC]);
		end else if (any_en) begin
			drive = 1'b1;
			assert_lvl = irq_act;
		end
		if (intc_ff[rtc_wd_irq_pkg::C_ACTIVE_HIGH]) begin
			nxt_int_out = drive & assert_lvl;
			nxt_int_oe = drive;
		end else begin
			nxt_int_out = 1'b0;
			nxt_int_oe = drive & assert_lvl;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pulse_ff <= 3'h0;
			irq_prev_ff <= 1'b0;
			int_out_ff <= 1'b0;
			int_oe_ff <= 1'b0;
		end else begin
			pulse_ff <= nxt_pulse;
			irq_prev_ff <= irq_cond;
			int_out_ff <= nxt_int_out;
			int_oe_ff <= nxt_int_oe;
		end
	end

	// Outputs straight from flops
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_int_out = int_out_ff;
	assign o_int_oe = int_oe_ff;

	// Checks on watchdog, flags and pin
	property p_wd_dec;
		@(posedge i_clk) disable iff (i_rst)
		(tick32 && !wd_load && wdc_ff[5:0] != 6'h00 && wd_cnt_ff > 6'h01)
			|=> (wd_cnt_ff == $past(wd_cnt_ff) - 6'h01);
	endproperty
	a_wd_dec: assert property (p_wd_dec) else $error("watchdog missed a decrement");

	property p_wd_osc_stop;
		@(posedge i_clk) disable iff (i_rst)
		(!osc_ok && !wd_load) |=> $stable(wd_cnt_ff);
	endproperty
	a_wd_osc_stop: assert property (p_wd_osc_stop) else $error("watchdog moved without osc");

	property p_wd_strobe;
		@(posedge i_clk) disable iff (i_rst)
		strobe |=> (wd_cnt_ff == wdc_ff[5:0]);
	endproperty
	a_wd_strobe: assert property (p_wd_strobe) else $error("strobe did not reload");

	property p_wd_expire;
		@(posedge i_clk) disable iff (i_rst)
		(tick32 && !wd_load && wd_cnt_ff == 6'h01 && wdc_ff[5:0] != 6'h00)
			|=> flags_ff[rtc_wd_irq_pkg::F_WD_EXPIRED];
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("expiry flag not set");

	property p_wd_lock;
		@(posedge i_clk) disable iff (i_rst)
		(wr_wd && i_avs_writedata[rtc_wd_irq_pkg::W_LOCK] && !i_nv_recall)
			|=> $stable(wdc_ff[5:0]);
	endproperty
	a_wd_lock: assert property (p_wd_lock) else $error("locked timeout changed");

	property p_wd_off;
		@(posedge i_clk) disable iff (i_rst)
		(wdc_ff[5:0] == 6'h00) |-> !wd_expire;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired");

	property p_read_clear;
		@(posedge i_clk) disable iff (i_rst)
		(flags_read && !wd_expire && !i_nv_recall && !i_avs_write)
			##1 (pin_sync_ff[rtc_wd_irq_pkg::P_ALARM] == pin_prev_ff[rtc_wd_irq_pkg::P_ALARM])
			|-> $past(flags_ff[rtc_wd_irq_pkg::F_WD_EXPIRED]) == 1'b0
			|| !flags_ff[rtc_wd_irq_pkg::F_WD_EXPIRED]
			|| $past(rep_ff[rtc_wd_irq_pkg::F_WD_EXPIRED]) == 1'b0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flags read did not clear");

	property p_backup_quiet;
		@(posedge i_clk) disable iff (i_rst)
		on_backup |=> !o_int_oe && !o_int_out;
	endproperty
	a_backup_quiet: assert property (p_backup_quiet) else $error("pin driven on backup");

	property p_level_irq;
		@(posedge i_clk) disable iff (i_rst)
		(irq_cond && !intc_ff[rtc_wd_irq_pkg::C_PULSE_MODE] && !intc_ff[rtc_wd_irq_pkg::C_SQW_EN]
			&& !flags_ff[rtc_wd_irq_pkg::F_CAL] && intc_ff[rtc_wd_irq_pkg::C_ACTIVE_HIGH])
			|=> o_int_oe && o_int_out;
	endproperty
	a_level_irq: assert property (p_level_irq) else $error("level interrupt not driven");
endmodule

/* File: logic/rtc_wd_irq_pkg.sv */
// Constants for the watchdog, flag and interrupt-pin logic of the RTC.
// Assumes a 125 MHz system clock and a 32.768 kHz oscillator level on a pin.
package rtc_wd_irq_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] REG_FLAGS = 4'h0;
	localparam logic [3:0] REG_INT_CTRL = 4'h6;
	localparam logic [3:0] REG_WD_CTRL = 4'h7;
	// Event flags fields
	localparam int F_WD_EXPIRED = 7;
	localparam int F_ALARM = 6;
	localparam int F_POWERFAIL = 5;
	localparam int F_OSC_FAILED = 4;
	localparam int F_BACKUP_FAIL = 3;
	localparam int F_CAL = 2;
	localparam int F_UNLOCK = 1;
	// Flags cleared by a flags read; oscillator-failed needs an explicit write
	localparam logic [7:0] READ_CLEAR_MASK = 8'he8;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	// Interrupt output control fields
	localparam int C_WD_IRQ_EN = 7;
	localparam int C_ALARM_IRQ_EN = 6;
	localparam int C_PF_IRQ_EN = 5;
	localparam int C_SQW_EN = 4;
	localparam int C_ACTIVE_HIGH = 3;
	localparam int C_PULSE_MODE = 2;
	localparam int C_FREQ_HI = 1;
	localparam int C_FREQ_LO = 0;
	localparam logic [7:0] INT_CTRL_RST = 8'h08;
	// Watchdog control fields
	localparam int W_STROBE = 7;
	localparam int W_LOCK = 6;
	localparam logic [6:0] WD_CTRL_RST = 7'h40;
	// Square-wave selections
	localparam logic [1:0] FREQ_1HZ = 2'h0;
	localparam logic [1:0] FREQ_512HZ = 2'h1;
	localparam logic [1:0] FREQ_4096HZ = 2'h2;
	// Pin vector positions
	localparam int P_OSC = 0;
	localparam int P_RUN = 1;
	localparam int P_BACKUP = 2;
	localparam int P_ALARM = 3;
	localparam int P_PF = 4;
	localparam int P_BKLOW = 5;
	localparam int P_OSCFAIL = 6;
	localparam int PIN_N = 7;
	// Time base
	localparam int OSC_HZ = 32768;
	localparam int TICK_HZ = 32;
	localparam int TICK_US = 31250;
	localparam logic [9:0] TICK_DIV_LAST = 10'(OSC_HZ / TICK_HZ - 1);
	localparam int PULSE_MS = 200;
	localparam int PULSE_TICKS = (PULSE_MS * 1000 + TICK_US - 1) / TICK_US;
endpackage

/* File: testbench/rtc_host_pin_model.sv */
// Host-side model: crystal source, pulled-up interrupt wire, power-up ignore window.
// Assumes the bench clock i_clk; oscillator runs fast so watchdog ticks fit the run.
`timescale 1ns/1ps
module rtc_host_pin_model #(
	parameter int IGNORE_CYCLES = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Oscillator control
	input wire logic i_osc_en,
	output logic o_osc_clk,
	// Interrupt pin from the device
	input wire logic i_int_out,
	input wire logic i_int_oe,
	output wire logic o_pin,
	output logic o_ignore
);
	logic [1:0] div_ff;
	int ign_ff;
	// Pull-up resistor wins whenever the device lets go of the wire
	assign o_pin = i_int_oe ? i_int_out : 1'b1;
	// Oscillator: six clocks per period, well above the two-flop sampling need
	// Reset start keeps the divider out of an unknown state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_ff <= 2'h0;
			o_osc_clk <= 1'b0;
		end else if (!i_osc_en) begin
			div_ff <= 2'h0;
		end else if (div_ff == 2'h2) begin
			div_ff <= 2'h0;
			o_osc_clk <= ~o_osc_clk;
		end else begin
			div_ff <= div_ff + 2'h1;
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ign_ff <= IGNORE_CYCLES;
		end else if (ign_ff > 0) begin
			ign_ff <= ign_ff - 1;
		end
	end
	assign o_ignore = (ign_ff > 0);
endmodule

/* File: testbench/tb_rtc_watchdog_interrupt_logic.sv */
// Bench for the watchdog, flags and interrupt-pin block, driven over Avalon-MM.
// Assumes one 125 MHz clock; oscillator comes from the host model, sped up.
`timescale 1ns/1ps
module tb_rtc_watchdog_interrupt_logic;
	logic i_clk, i_rst, i_avs_read, i_avs_write, i_nv_recall;
	logic [5:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic o_avs_waitrequest, o_int_out, o_int_oe, int_pin, ignore, osc;
	logic [7:0] i_nv_int_ctrl, i_nv_wd_ctrl, d;
	logic i_osc_running, i_on_backup, i_alarm_match, i_powerfail, i_backup_low, i_osc_fail;
	int n_fail, check_count, t;
	bit seen;
	// Design with a short pulse so pulse mode fits the run
	rtc_watchdog_interrupt_logic #(.PULSE_TICKS(2)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_nv_recall(i_nv_recall),
		.i_nv_int_ctrl(i_nv_int_ctrl), .i_nv_wd_ctrl(i_nv_wd_ctrl), .i_osc_clk(osc),
		.i_osc_running(i_osc_running), .i_on_backup(i_on_backup),
		.i_alarm_match(i_alarm_match), .i_powerfail(i_powerfail),
		.i_backup_low(i_backup_low), .i_osc_fail(i_osc_fail),
		.o_int_out(o_int_out), .o_int_oe(o_int_oe));
	rtc_host_pin_model i_host (.i_clk(i_clk), .i_rst(i_rst), .i_osc_en(1'b1), .o_osc_clk(osc),
		.i_int_out(o_int_out), .i_int_oe(o_int_oe), .o_pin(int_pin), .o_ignore(ignore));
	// Clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// Bus access: hold the request until waitrequest is sampled low
	task automatic bus(input bit wr, input logic [3:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		i_avs_address <= {idx, 2'b00};
		i_avs_writedata <= {24'h0, wd};
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) chk(8'h00, 8'h01, "bus hang");
		d = o_avs_readdata[7:0];
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_clk);
	endtask
	// Wait, bounded, until the pin is (want=1) or is not active
	task automatic wait_pin(input bit hi, input bit want, input int lim);
		seen = 0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(posedge i_clk);
			if ((hi ? (o_int_oe === 1'b1 && o_int_out === 1'b1) : (int_pin === 1'b0)) == want)
				seen = 1;
		end
	endtask
	// Toggles of the pin value over n cycles
	task automatic toggles(input int n);
		logic p;
		// Let the new setting reach the pin before counting
		repeat (2) @(posedge i_clk);
		p = o_int_out;
		t = 0;
		repeat (n) begin
			@(posedge i_clk);
			if (o_int_out !== p) t++;
			p = o_int_out;
		end
	endtask
	task automatic rng(input int lo, input int hi, input string msg);
		chk({7'h0, t >= lo && t <= hi}, 8'h01, msg);
	endtask
	// Input pulse on an event line: 0 alarm, 1 power fail, 2 backup low, 3 osc fail
	task automatic ev(input int sel);
		case (sel)
			0: i_alarm_match <= 1'b1;
			1: i_powerfail <= 1'b1;
			2: i_backup_low <= 1'b1;
			default: i_osc_fail <= 1'b1;
		endcase
		repeat (4) @(posedge i_clk);
		{i_alarm_match, i_powerfail, i_backup_low, i_osc_fail} <= 4'h0;
		repeat (10) @(posedge i_clk);
	endtask
	// Watchdog well past the expected run length
	initial begin
		#(8 * 95000);
		n_fail++;
		conclude();
	end
	initial begin
		{i_avs_read, i_avs_write, i_nv_recall, i_on_backup, i_alarm_match} = '0;
		{i_powerfail, i_backup_low, i_osc_fail} = '0;
		i_avs_address = 6'h00;
		i_avs_writedata = 32'h0;
		i_nv_int_ctrl = 8'h88;
		i_nv_wd_ctrl = 8'h02;
		i_osc_running = 1'b1;
		i_rst = 1'b1;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "flags reset");
		bus(0, 4'h6, 8'h0); chk(d, 8'h08, "int ctrl reset");
		bus(0, 4'h7, 8'h0); chk(d & 8'h7f, 8'h40, "wd ctrl reset");
		bus(0, 4'h3, 8'h0); chk(d, 8'h00, "unmapped read");
		$display("test reset done");
		// Power-up recall: timeout 2, watchdog irq on, active high level
		i_nv_recall <= 1'b1;
		@(posedge i_clk);
		i_nv_recall <= 1'b0;
		wait (!ignore);
		@(posedge i_clk);
		wait_pin(1, 1, 15000); chk({7'h0, seen}, 8'h01, "expiry irq");
		bus(0, 4'h0, 8'h0); chk(d, 8'h80, "expired flag");
		repeat (3) @(posedge i_clk);
		chk({6'h0, o_int_oe, o_int_out}, 8'h02, "pin inactive after read");
		$display("test recall expiry done");
		bus(1, 4'h7, 8'h45); bus(0, 4'h7, 8'h0); chk(d & 8'h7f, 8'h42, "locked");
		bus(1, 4'h7, 8'h05); bus(0, 4'h7, 8'h0); chk(d & 8'h7f, 8'h05, "unlocked");
		bus(1, 4'h7, 8'h80); bus(0, 4'h0, 8'h0);
		repeat (14000) @(posedge i_clk);
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "zero timeout idle");
		$display("test lock and disable done");
		// Host strobes well inside each three-tick window
		bus(1, 4'h7, 8'h83);
		repeat (3) begin
			repeat (5000) @(posedge i_clk);
			bus(1, 4'h7, 8'h83);
		end
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "refreshed, no expiry");
		i_osc_running <= 1'b0;
		bus(1, 4'h7, 8'h81);
		repeat (8000) @(posedge i_clk);
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "oscillator stopped");
		$display("test refresh done");
		bus(1, 4'h6, 8'h8c);
		bus(1, 4'h7, 8'h81);
		i_osc_running <= 1'b1;
		wait_pin(1, 1, 8000); chk({7'h0, seen}, 8'h01, "pulse start");
		wait_pin(1, 0, 19000); chk({7'h0, seen}, 8'h01, "pulse ends alone");
		bus(1, 4'h7, 8'h80);
		bus(0, 4'h0, 8'h0); chk(d & 8'h80, 8'h80, "flag outlives pulse");
		bus(0, 4'h0, 8'h0);
		$display("test pulse done");
		bus(1, 4'h6, 8'h08);
		ev(0); chk({7'h0, o_int_oe}, 8'h00, "alarm masked");
		bus(0, 4'h0, 8'h0); chk(d, 8'h40, "alarm flag");
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "cleared by read");
		bus(1, 4'h6, 8'h48);
		ev(0); chk({7'h0, o_int_oe & o_int_out}, 8'h01, "alarm irq");
		bus(0, 4'h0, 8'h0); chk(d, 8'h40, "alarm flag");
		bus(1, 4'h6, 8'h20);
		ev(1); chk({7'h0, int_pin}, 8'h00, "open drain low");
		chk({6'h0, o_int_oe, o_int_out}, 8'h02, "open drain drive");
		bus(0, 4'h0, 8'h0); chk(d, 8'h20, "powerfail flag");
		ev(3); bus(0, 4'h0, 8'h0); chk(d, 8'h10, "osc failed flag");
		bus(0, 4'h0, 8'h0); chk(d, 8'h10, "osc flag kept by read");
		bus(1, 4'h0, 8'h02); bus(1, 4'h0, 8'h00);
		bus(0, 4'h0, 8'h0); chk(d, 8'h00, "osc flag written off");
		$display("test sources done");
		bus(1, 4'h6, 8'h48);
		i_on_backup <= 1'b1;
		ev(0); chk({7'h0, o_int_oe}, 8'h00, "no irq on backup");
		ev(2);
		i_on_backup <= 1'b0;
		repeat (10) @(posedge i_clk);
		bus(0, 4'h0, 8'h0); chk(d & 8'h08, 8'h08, "backup fail flag");
		bus(1, 4'h6, 8'h1b);
		i_on_backup <= 1'b1;
		repeat (10) @(posedge i_clk);
		toggles(200); rng(0, 0, "no wave on backup");
		chk({7'h0, o_int_oe}, 8'h00, "wave off on backup");
		i_on_backup <= 1'b0;
		bus(0, 4'h0, 8'h0);
		$display("test backup done");
		bus(1, 4'h6, 8'h19); toggles(400); rng(1, 3, "512 Hz");
		bus(1, 4'h6, 8'h1a); toggles(400); rng(12, 20, "4096 Hz");
		bus(1, 4'h6, 8'h1b); toggles(400); rng(100, 140, "32768 Hz");
		bus(1, 4'h0, 8'h02);
		bus(1, 4'h0, 8'h06);
		bus(1, 4'h0, 8'h04);
		toggles(400); rng(1, 3, "test tone first");
		bus(1, 4'h0, 8'h02);
		bus(1, 4'h0, 8'h00);
		bus(1, 4'h6, 8'h08);
		repeat (4) @(posedge i_clk);
		chk({7'h0, o_int_oe}, 8'h00, "pin released");
		$display("test square wave done");
		conclude();
	end
endmodule
